//--- include/cise_consts.vh
// constants for the instruction subset execution block
`ifndef CISE_CONSTS_VH
`define CISE_CONSTS_VH
// operation select codes on opSel
`define CISE_OP_NONE         3'h0
`define CISE_OP_CLEAR_ACCUM  3'h1
`define CISE_OP_DEC_SKIP     3'h2
`define CISE_OP_INC_SKIP     3'h3
`define CISE_OP_BRANCH       3'h4
`define CISE_OP_OR_LITERAL   3'h5
`define CISE_OP_INC_FILE     3'h6
// widths and field positions
`define CISE_DATA_W          8
`define CISE_PC_W            15
`define CISE_ADDR_W          7
`define CISE_IMM_W           11
`define CISE_LATCH_HI        6
`define CISE_LATCH_LO        3
// reset and constant values
`define CISE_ACCUM_RST       8'h00
`define CISE_ZERO_RST        1'h0
`define CISE_PC_RST          15'h0000
`define CISE_NOP_RST         1'h0
`define CISE_WREN_RST        1'h0
`define CISE_ADDR_RST        7'h00
`define CISE_WRDATA_RST      8'h00
`define CISE_CLEAR_VAL       8'h00
`define CISE_ONE             8'h01
`define CISE_PC_ONE          15'h0001
`endif

//--- rtl/cise_exec.v
// execution logic for a subset of an 8-bit core instruction set
//
// Overview of operation
// - clear accumulator loads zero, sets zero flag
// - decrement file; dest bit picks accumulator or file
// - decrement result zero skips next, flags untouched
// - increment file; dest bit picks target; plain updates zero
// - increment result zero skips next, flags untouched
// - branch loads immediate, upper bits from latch
// - branch takes two cycles, flushes fetch, no flags
// - OR literal into accumulator, update zero flag
`default_nettype none
`include "cise_consts.vh"

module cise_exec (
   input  wire                      ref_clk,
   input  wire                      rst,
   input  wire                      insnValid,
   input  wire [2:0]                opSel,
   input  wire                      destBit,
   input  wire [`CISE_ADDR_W-1:0]   fileAddr,
   input  wire [`CISE_IMM_W-1:0]    immOperand,
   input  wire [`CISE_DATA_W-1:0]   fileRdData,
   input  wire [6:0]                pcUpperLatch,
   output reg  [`CISE_DATA_W-1:0]   accum_q,
   output reg                       zeroFlag_q,
   output reg  [`CISE_PC_W-1:0]     pc_q,
   output reg                       fileWrEn_q,
   output reg  [`CISE_ADDR_W-1:0]   fileWrAddr_q,
   output reg  [`CISE_DATA_W-1:0]   fileWrData_q,
   output wire                      nopCycle,
   output wire                      insnTaken
);

   // ************************************************
   // helpers
   // ************************************************
   function isZero;
      input [`CISE_DATA_W-1:0] val;
      begin
         isZero = (val == `CISE_CLEAR_VAL);
      end
   endfunction

   // the three file arithmetic operations share one write-back path
   function readsFile;
      input [2:0] op;
      begin
         case (op)
            `CISE_OP_DEC_SKIP: readsFile = 1'h1;
            `CISE_OP_INC_SKIP: readsFile = 1'h1;
            `CISE_OP_INC_FILE: readsFile = 1'h1;
            default:           readsFile = 1'h0;
         endcase
      end
   endfunction

   function isSkipOp;
      input [2:0] op;
      begin
         isSkipOp = (op == `CISE_OP_DEC_SKIP) | (op == `CISE_OP_INC_SKIP);
      end
   endfunction

   function [`CISE_DATA_W-1:0] fileResult;
      input [2:0]              op;
      input [`CISE_DATA_W-1:0] data;
      begin
         if (op == `CISE_OP_DEC_SKIP) begin
            fileResult = data - `CISE_ONE;
         end else begin
            fileResult = data + `CISE_ONE;
         end
      end
   endfunction

   // ************************************************
   // state
   // ************************************************
   // nopPending_q marks the forced NOP cycle; nopIsSkip_q tells whether
   // the discarded word still advances the counter (skip) or not (branch)
   reg                      nopPending_q;
   reg                      nopPending_d;
   reg                      nopIsSkip_q;
   reg                      nopIsSkip_d;
   reg [`CISE_DATA_W-1:0]   accum_d;
   reg                      zeroFlag_d;
   reg [`CISE_PC_W-1:0]     pc_d;
   reg                      fileWrEn_d;
   reg [`CISE_ADDR_W-1:0]   fileWrAddr_d;
   reg [`CISE_DATA_W-1:0]   fileWrData_d;
   wire                     execNow;
   wire [`CISE_DATA_W-1:0]  fileRes;
   wire [`CISE_DATA_W-1:0]  orResult;
   wire [`CISE_PC_W-1:0]    pcNext;
   wire [`CISE_PC_W-1:0]    branchTarget;

   assign execNow      = insnValid & ~nopPending_q;
   assign fileRes      = fileResult(opSel, fileRdData);
   assign orResult     = accum_q | immOperand[`CISE_DATA_W-1:0];
   assign pcNext       = pc_q + `CISE_PC_ONE;
   assign branchTarget = {pcUpperLatch[`CISE_LATCH_HI:`CISE_LATCH_LO], immOperand};
   assign nopCycle     = nopPending_q;
   // a word offered during the forced NOP is discarded, not executed
   assign insnTaken    = execNow;

   // ************************************************
   // accumulator and zero flag
   // ************************************************
   always @* begin
      accum_d    = accum_q;
      zeroFlag_d = zeroFlag_q;
      if (execNow) begin
         case (opSel)
            `CISE_OP_CLEAR_ACCUM: begin
               accum_d    = `CISE_CLEAR_VAL;
               zeroFlag_d = 1'h1;
            end
            `CISE_OP_DEC_SKIP: begin
               // skip forms may write the accumulator but never the flag
               if (!destBit) begin
                  accum_d = fileRes;
               end
            end
            `CISE_OP_INC_SKIP: begin
               if (!destBit) begin
                  accum_d = fileRes;
               end
            end
            `CISE_OP_OR_LITERAL: begin
               accum_d    = orResult;
               zeroFlag_d = isZero(orResult);
            end
            `CISE_OP_INC_FILE: begin
               if (!destBit) begin
                  accum_d = fileRes;
               end
               zeroFlag_d = isZero(fileRes);
            end
            default: begin
               // branch and the unlisted codes leave both untouched
               accum_d    = accum_q;
               zeroFlag_d = zeroFlag_q;
            end
         endcase
      end
   end

   // ************************************************
   // file write-back
   // ************************************************
   // the write is a registered pulse, one cycle after the operation
   always @* begin
      fileWrEn_d   = 1'h0;
      fileWrAddr_d = fileAddr;
      fileWrData_d = fileWrData_q;
      if (execNow && readsFile(opSel) && destBit) begin
         fileWrEn_d   = 1'h1;
         fileWrData_d = fileRes;
      end
   end

   // ************************************************
   // program counter and forced NOP
   // ************************************************
   always @* begin
      pc_d         = pc_q;
      nopPending_d = 1'h0;
      nopIsSkip_d  = 1'h0;
      if (nopPending_q) begin
         // second cycle: the flushed word is dropped here
         if (nopIsSkip_q) begin
            pc_d = pcNext;
         end
      end else if (insnValid) begin
         case (opSel)
            `CISE_OP_BRANCH: begin
               // the word fetched behind the branch is flushed, pc holds then
               pc_d         = branchTarget;
               nopPending_d = 1'h1;
            end
            default: begin
               pc_d = pcNext;
               if (isSkipOp(opSel)) begin
                  nopPending_d = isZero(fileRes);
                  nopIsSkip_d  = 1'h1;
               end
            end
         endcase
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         accum_q    <= `CISE_ACCUM_RST;
         zeroFlag_q <= `CISE_ZERO_RST;
      end else begin
         accum_q    <= accum_d;
         zeroFlag_q <= zeroFlag_d;
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pc_q         <= `CISE_PC_RST;
         nopPending_q <= `CISE_NOP_RST;
         nopIsSkip_q  <= `CISE_NOP_RST;
      end else begin
         pc_q         <= pc_d;
         nopPending_q <= nopPending_d;
         nopIsSkip_q  <= nopIsSkip_d;
      end
   end

   // write-back resets quiet so no stray write follows reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fileWrEn_q   <= `CISE_WREN_RST;
         fileWrAddr_q <= `CISE_ADDR_RST;
         fileWrData_q <= `CISE_WRDATA_RST;
      end else begin
         fileWrEn_q   <= fileWrEn_d;
         fileWrAddr_q <= fileWrAddr_d;
         fileWrData_q <= fileWrData_d;
      end
   end

endmodule
`default_nettype wire

//--- verification/cise_exec_checker.sv
// port assertions for the instruction subset execution block
`default_nettype none
module cise_exec_checker (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        insnTaken,
   input wire logic        destBit,
   input wire logic        zeroFlag_q,
   input wire logic        fileWrEn_q,
   input wire logic        nopCycle,
   input wire logic [2:0]  opSel,
   input wire logic [6:0]  pcUpperLatch,
   input wire logic [7:0]  fileRdData,
   input wire logic [7:0]  accum_q,
   input wire logic [7:0]  fileWrData_q,
   input wire logic [10:0] immOperand,
   input wire logic [14:0] pc_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic [14:0] tgt = {pcUpperLatch[6:3], immOperand};
   wire logic [7:0]  lit = immOperand[7:0];
   a_clear_sets_zero: assert property (insnTaken && opSel == 3'h1 |=>
      accum_q == 8'h00 && zeroFlag_q) else $error("clear");
   a_dec_to_file: assert property (insnTaken && opSel == 3'h2 && destBit |=>
      fileWrEn_q && fileWrData_q == $past(fileRdData) - 8'h01) else $error("dec");
   a_dec_skip_nop: assert property (insnTaken && opSel == 3'h2 |=>
      nopCycle == ($past(fileRdData) == 8'h01) ##1 !(nopCycle && $past(nopCycle)))
      else $error("dec skip");
   a_skip_keeps_flag: assert property (insnTaken && opSel inside {3'h2, 3'h3} |=>
      $stable(zeroFlag_q)) else $error("skip flag");
   a_inc_skip_nop: assert property (insnTaken && opSel == 3'h3 |=>
      nopCycle == ($past(fileRdData) == 8'hFF) ##1 !(nopCycle && $past(nopCycle)))
      else $error("inc skip");
   a_inc_result: assert property (insnTaken && opSel == 3'h6 && !destBit |=>
      accum_q == $past(fileRdData) + 8'h01 && zeroFlag_q == !accum_q) else $error("inc");
   a_branch_target: assert property (insnTaken && opSel == 3'h4 |=>
      pc_q == $past(tgt) && nopCycle && $stable(zeroFlag_q) ##1 $stable(pc_q) && !nopCycle)
      else $error("branch");
   a_or_literal: assert property (insnTaken && opSel == 3'h5 |=>
      accum_q == ($past(accum_q) | $past(lit)) && zeroFlag_q == !accum_q) else $error("or");
   c_dec_skip: cover property (insnTaken && opSel == 3'h2 ##1 nopCycle);
   c_two_branches: cover property (insnTaken && opSel == 3'h4 ##2 insnTaken && opSel == 3'h4);
   c_inc_wrap: cover property (insnTaken && opSel == 3'h6 ##1 zeroFlag_q);
endmodule
bind cise_exec cise_exec_checker u_chk (.ref_clk, .rst, .insnTaken, .destBit, .zeroFlag_q,
   .fileWrEn_q, .nopCycle, .opSel, .pcUpperLatch, .fileRdData, .accum_q, .fileWrData_q,
   .immOperand, .pc_q);
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the instruction subset execution block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst = 1, insnValid = 0, destBit = 0, z = 0, tk = 0, sk, we;
   logic [2:0] opSel = 0;
   logic [6:0] fileAddr = 0, pcUpperLatch = 0, fileWrAddr_q;
   logic [10:0] immOperand = 0;
   logic [7:0] fileRdData = 0, accum_q, fileWrData_q, acc = 0, r;
   logic zeroFlag_q, fileWrEn_q, nopCycle, insnTaken;
   logic [14:0] pc_q, pc = 0;
   logic [41:0] q[$];
   // write address and data only count while the write strobe is up
   wire logic [41:0] st = {accum_q, zeroFlag_q, pc_q, nopCycle, insnTaken, fileWrEn_q,
      fileWrEn_q ? fileWrAddr_q : 7'h00, fileWrEn_q ? fileWrData_q : 8'h00};
   int failures = 0, n_checks = 0, seed = 62;
   cise_exec u_dut (.ref_clk, .rst, .insnValid, .opSel, .destBit, .fileAddr, .immOperand,
      .fileRdData, .pcUpperLatch, .accum_q, .zeroFlag_q, .pc_q, .fileWrEn_q, .fileWrAddr_q,
      .fileWrData_q, .nopCycle, .insnTaken);
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(logic [41:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] state expected %h seen %h", exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // taken is sampled mid-cycle so the flag of the launching edge has settled
   always @(negedge ref_clk) tk = insnTaken;
   always @(posedge ref_clk) begin
      #1;
      if (tk && q.size() > 0) chk(st, q.pop_front());
   end
   task automatic ex(logic [2:0] op, logic [7:0] f);
      @(posedge ref_clk);
      #2;
      insnValid = 1;
      opSel = op;
      fileRdData = f;
      {destBit, immOperand, pcUpperLatch, fileAddr} = 26'($random(seed));
      r = op == 3'h2 ? f - 8'h01 : f + 8'h01;
      sk = (op == 3'h2 || op == 3'h3) && r == 8'h00 || op == 3'h4;
      if ((op == 3'h2 || op == 3'h3 || op == 3'h6) && !destBit) acc = r;
      if (op == 3'h1) acc = 8'h00;
      if (op == 3'h5) acc = acc | immOperand[7:0];
      if (op == 3'h1 || op == 3'h5 || op == 3'h6) z = (op == 3'h6 ? r : acc) == 8'h00;
      pc = op == 3'h4 ? {pcUpperLatch[6:3], immOperand} : pc + 15'h0001;
      we = (op == 3'h2 || op == 3'h3 || op == 3'h6) && destBit;
      q.push_back({acc, z, pc, sk, !sk, we, we ? fileAddr : 7'h00, we ? r : 8'h00});
      if (sk) begin
         @(posedge ref_clk);
         #2;
         // garbage in the forced nop slot must be dropped
         opSel = 3'($random(seed));
         if (op != 3'h4) pc = pc + 15'h0001;
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      #2;
      rst = 0;
      chk(st, 42'h00000000000);
      $display("reset test done");
      repeat (60) ex(3'($random(seed)), 8'($random(seed)));
      $display("random mix test done");
      ex(3'h2, 8'h01);
      ex(3'h3, 8'hFF);
      ex(3'h4, 8'h00);
      ex(3'h4, 8'h00);
      ex(3'h6, 8'hFF);
      ex(3'h1, 8'h00);
      ex(3'h5, 8'h00);
      $display("directed test done");
      @(posedge ref_clk);
      #2;
      insnValid = 0;
      repeat (3) @(posedge ref_clk);
      #2;
      chk(st, {acc, z, pc, 18'h00000});
      $display("idle test done");
      report_and_stop;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      report_and_stop;
   end
endmodule
`default_nettype wire
